/* File: inc/spis_defs.svh */
// Offsets, field positions, reset values and counts of the serial port interrupt select block
`ifndef SPIS_DEFS_SVH
`define SPIS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SPIS_OFF_RX_HIGH    8'h00
`define SPIS_OFF_RX_LOW     8'h04
`define SPIS_OFF_TX_HIGH    8'h08
`define SPIS_OFF_TX_LOW     8'h0c
`define SPIS_OFF_CTRL       8'h10
`define SPIS_OFF_STATUS     8'h14
`define SPIS_OFF_IRQ_EN     8'h18
`define SPIS_OFF_CHAN_BASE  8'h20
`define SPIS_OFF_CHAN_LAST  8'h3c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPIS_CTRL_RX_MODE   1:0
`define SPIS_CTRL_TX_MODE   3:2
`define SPIS_CTRL_MC_MODE   5:4
`define SPIS_CTRL_WIDE      6
`define SPIS_ST_RX_READY    0
`define SPIS_ST_RX_OVERRUN  1
`define SPIS_ST_RX_SYNCERR  2
`define SPIS_ST_TX_READY    3
`define SPIS_ST_TX_SYNCERR  4
`define SPIS_IEN_RX_GATE    2
`define SPIS_IEN_TX_GATE    0
`define SPIS_IEN_MASK       16'h0005

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SPIS_RST_CTRL       7'h00
`define SPIS_RST_IRQ_EN     16'h0000
`define SPIS_RST_CHAN       16'h0000
`define SPIS_CHAN_BLOCKS    8

`endif

/* File: inc/spis_pkg.sv */
// Types shared by the serial port interrupt select block
package spis_pkg;

  // Interrupt source picked by a 2-bit mode field
  typedef enum logic [1:0] {
    SPIS_SRC_WORD,
    SPIS_SRC_BLOCK,
    SPIS_SRC_FSYNC,
    SPIS_SRC_SYNCERR
  } spis_irq_src_type;

  // Transmit multichannel selection mode
  typedef enum logic [1:0] {
    SPIS_MC_OFF,
    SPIS_MC_SELECT,
    SPIS_MC_MASKED,
    SPIS_MC_SYMMETRIC
  } spis_mc_mode_type;

  // Bus slave phase
  typedef enum logic {
    SPIS_BUS_IDLE,
    SPIS_BUS_DATA
  } spis_bus_state_type;

endpackage

/* File: logic/spis_irq_sel.sv */
// One direction's interrupt source selector and enable gate
`timescale 1ns/100ps
`include "spis_defs.svh"

module spis_irq_sel
  import spis_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // Selection
  input  wire spis_irq_src_type mode,
  input  wire logic             gate,
  // Sources
  input  wire logic             src_word,
  input  wire logic             src_block,
  input  wire logic             src_fsync,
  input  wire logic             src_syncerr,
  // Interrupt line
  output logic                  irq_q
);

  logic sel;

  // Only the chosen source reaches the line
  always_comb begin
    case (mode)
      SPIS_SRC_WORD:    sel = src_word;
      SPIS_SRC_BLOCK:   sel = src_block;
      SPIS_SRC_FSYNC:   sel = src_fsync;
      SPIS_SRC_SYNCERR: sel = src_syncerr;
      default:          sel = 1'b0;
    endcase
  end

  // Registered so the line never glitches while the mode changes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= sel & gate;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_block_pick: assert property (mode == SPIS_SRC_BLOCK && !src_block |=> !irq_q)
    else $error("line rose without the block source");
  a_fsync_pick: assert property (mode == SPIS_SRC_FSYNC && gate && src_fsync |=> irq_q)
    else $error("frame sync source did not reach the line");

endmodule

/* File: logic/spis_top.sv */
// Serial port interrupt select, status flags, data pairs and channel map behind an AHB-Lite slave
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "spis_defs.svh"

module spis_top
  import spis_pkg::*;
#(
  parameter int CHAN_BLOCKS = `SPIS_CHAN_BLOCKS
)(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Receive events from the serial core
  input  wire logic        rx_word_done,
  input  wire logic [31:0] rx_word,
  input  wire logic        rx_block_end,
  input  wire logic        rx_frame_sync,
  input  wire logic        rx_fs_unexpected,
  // Transmit events from the serial core
  input  wire logic        tx_word_taken,
  input  wire logic        tx_block_end,
  input  wire logic        tx_frame_sync,
  input  wire logic        tx_fs_unexpected,
  // Transmit channel slot query
  input  wire logic [6:0]  tx_chan_idx,
  input  wire logic        rx_chan_enabled,
  output logic             tx_slot_enable,
  output logic             tx_slot_unmask,
  // Serial core control
  output logic [31:0]      tx_data_out,
  output logic             rx_restart,
  output logic             tx_restart,
  // CPU and DMA requests
  output logic             rx_cpu_irq_line,
  output logic             tx_cpu_irq_line,
  output logic             rx_dma_event,
  output logic             tx_dma_event
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (CHAN_BLOCKS != 8) begin : g_bad_blocks
    $error("CHAN_BLOCKS must be 8");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  spis_bus_state_type bus_q;
  logic [7:0]         addr_q;
  logic               wr_q;
  logic [15:0]        rx_high_q;
  logic [15:0]        rx_low_q;
  logic [15:0]        tx_high_q;
  logic [15:0]        tx_low_q;
  logic [6:0]         ctrl_q;
  logic [15:0]        irq_en_q;
  logic [15:0]        chan_en_q [CHAN_BLOCKS];
  logic               rx_word_ready_q;
  logic               rx_overrun_q;
  logic               rx_sync_error_q;
  logic               tx_word_ready_q;
  logic               tx_sync_error_q;
  logic               hreadyout_q;
  logic               hresp_q;
  logic [31:0]        hrdata_q;
  logic               rx_restart_q;
  logic               tx_restart_q;
  logic               rx_dma_q;
  logic               tx_dma_q;
  logic               slot_en_q;
  logic               slot_um_q;

  // Data phase strobes, decoded control fields and the channel bit
  logic wr_stb;
  logic rd_stb;
  logic st_clr_wr;
  logic rd_rx_low;
  logic wr_tx_low;
  logic rx_irq_gate;
  logic tx_irq_gate;
  spis_irq_src_type rx_irq_mode;
  spis_irq_src_type tx_irq_mode;
  spis_mc_mode_type tx_multichannel_mode;
  logic tx_wide_channel_select;
  logic chan_bit;

  // Index of a channel enable register, or an out-of-range marker
  function automatic logic [3:0] chan_reg(input logic [7:0] a);
    if (a >= `SPIS_OFF_CHAN_BASE && a <= `SPIS_OFF_CHAN_LAST) begin
      chan_reg = {1'b0, 3'(a[4:2])};
    end else begin
      chan_reg = 4'h8;
    end
  endfunction

  // Channel bit: wide select uses all eight blocks, narrow uses the first two
  function automatic logic chan_pick(input logic [6:0] idx, input logic wide);
    logic [2:0] blk;
    blk = wide ? idx[6:4] : {2'b00, idx[4]};
    chan_pick = chan_en_q[blk][idx[3:0]];
  endfunction

  assign wr_stb                 = (bus_q == SPIS_BUS_DATA) && wr_q;
  assign rd_stb                 = (bus_q == SPIS_BUS_DATA) && !wr_q;
  assign st_clr_wr              = wr_stb && addr_q == `SPIS_OFF_STATUS;
  assign rd_rx_low              = rd_stb && addr_q == `SPIS_OFF_RX_LOW;
  assign wr_tx_low              = wr_stb && addr_q == `SPIS_OFF_TX_LOW;
  assign rx_irq_gate            = irq_en_q[`SPIS_IEN_RX_GATE];
  assign tx_irq_gate            = irq_en_q[`SPIS_IEN_TX_GATE];
  assign rx_irq_mode            = spis_irq_src_type'(ctrl_q[`SPIS_CTRL_RX_MODE]);
  assign tx_irq_mode            = spis_irq_src_type'(ctrl_q[`SPIS_CTRL_TX_MODE]);
  assign tx_multichannel_mode   = spis_mc_mode_type'(ctrl_q[`SPIS_CTRL_MC_MODE]);
  assign tx_wide_channel_select = ctrl_q[`SPIS_CTRL_WIDE];
  assign chan_bit               = chan_pick(tx_chan_idx, tx_wide_channel_select);

  // ----------------------------------------------------------------
  // AHB-Lite slave: one wait state on every transfer
  // ----------------------------------------------------------------
  // The wait state lets read data come from a flop at no decode cost
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_q       <= SPIS_BUS_IDLE;
      addr_q      <= 8'h00;
      wr_q        <= 1'b0;
      hreadyout_q <= 1'b1;
    end else begin
      case (bus_q)
        SPIS_BUS_IDLE: begin
          if (hsel && htrans[1] && hready) begin
            bus_q       <= SPIS_BUS_DATA;
            addr_q      <= haddr[7:0];
            wr_q        <= hwrite;
            hreadyout_q <= 1'b0;
          end
        end
        SPIS_BUS_DATA: begin
          bus_q       <= SPIS_BUS_IDLE;
          hreadyout_q <= 1'b1;
        end
        default: begin
          bus_q       <= SPIS_BUS_IDLE;
          hreadyout_q <= 1'b1;
        end
      endcase
    end
  end

  // Response is always OKAY
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read as zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_stb) begin
      case (addr_q)
        `SPIS_OFF_RX_HIGH: hrdata_q <= {16'h0000, rx_high_q};
        `SPIS_OFF_RX_LOW:  hrdata_q <= {16'h0000, rx_low_q};
        `SPIS_OFF_TX_HIGH: hrdata_q <= {16'h0000, tx_high_q};
        `SPIS_OFF_TX_LOW:  hrdata_q <= {16'h0000, tx_low_q};
        `SPIS_OFF_CTRL:    hrdata_q <= {25'h0000000, ctrl_q};
        `SPIS_OFF_STATUS:  hrdata_q <= {27'h0000000, tx_sync_error_q, tx_word_ready_q,
                                        rx_sync_error_q, rx_overrun_q, rx_word_ready_q};
        `SPIS_OFF_IRQ_EN:  hrdata_q <= {16'h0000, irq_en_q};
        default: begin
          if (chan_reg(addr_q) != 4'h8) begin
            hrdata_q <= {16'h0000, chan_en_q[3'(chan_reg(addr_q))]};
          end else begin
            hrdata_q <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Control, enable and transmit data pair
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_q    <= `SPIS_RST_CTRL;
      irq_en_q  <= `SPIS_RST_IRQ_EN;
      tx_high_q <= 16'h0000;
      tx_low_q  <= 16'h0000;
    end else if (wr_stb) begin
      case (addr_q)
        `SPIS_OFF_CTRL:    ctrl_q    <= hwdata[6:0];
        `SPIS_OFF_IRQ_EN:  irq_en_q  <= hwdata[15:0] & `SPIS_IEN_MASK;
        `SPIS_OFF_TX_HIGH: tx_high_q <= hwdata[15:0];
        `SPIS_OFF_TX_LOW:  tx_low_q  <= hwdata[15:0];
        default:           ctrl_q    <= ctrl_q;
      endcase
    end
  end

  // Channel enable registers, one per 16-channel block
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int b = 0; b < CHAN_BLOCKS; b++) begin
        chan_en_q[b] <= `SPIS_RST_CHAN;
      end
    end else if (wr_stb && chan_reg(addr_q) != 4'h8) begin
      chan_en_q[3'(chan_reg(addr_q))] <= hwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Receive data pair and flags
  // ----------------------------------------------------------------
  // A word lands when the pair is free or its low half is read in the same cycle; otherwise it is lost
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_high_q <= 16'h0000;
      rx_low_q  <= 16'h0000;
    end else if (rx_word_done && (!rx_word_ready_q || rd_rx_low)) begin
      rx_high_q <= rx_word[31:16];
      rx_low_q  <= rx_word[15:0];
    end
  end

  // Reading the low half frees the pair; a new word wins the race
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_word_ready_q <= 1'b0;
    end else if (rx_word_done) begin
      rx_word_ready_q <= 1'b1;
    end else if (rd_rx_low) begin
      rx_word_ready_q <= 1'b0;
    end
  end

  // Overrun: pair unread when the next word overwrites the shifter
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_overrun_q <= 1'b0;
    end else if (rx_word_done && rx_word_ready_q && !rd_rx_low) begin
      rx_overrun_q <= 1'b1;
    end else if (rd_rx_low || (st_clr_wr && hwdata[`SPIS_ST_RX_OVERRUN])) begin
      rx_overrun_q <= 1'b0;
    end
  end

  // Sticky receive sync error, cleared by writing one
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_sync_error_q <= 1'b0;
    end else if (rx_fs_unexpected) begin
      rx_sync_error_q <= 1'b1;
    end else if (st_clr_wr && hwdata[`SPIS_ST_RX_SYNCERR]) begin
      rx_sync_error_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit flags
  // ----------------------------------------------------------------
  // Ready after reset; writing the low half fills the pair
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_word_ready_q <= 1'b1;
    end else if (tx_word_taken) begin
      tx_word_ready_q <= 1'b1;
    end else if (wr_tx_low) begin
      tx_word_ready_q <= 1'b0;
    end
  end

  // Sticky transmit sync error, cleared by writing one
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_sync_error_q <= 1'b0;
    end else if (tx_fs_unexpected) begin
      tx_sync_error_q <= 1'b1;
    end else if (st_clr_wr && hwdata[`SPIS_ST_TX_SYNCERR]) begin
      tx_sync_error_q <= 1'b0;
    end
  end

  // Abort and restart pulses to the serial core
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_restart_q <= 1'b0;
      tx_restart_q <= 1'b0;
    end else begin
      rx_restart_q <= rx_fs_unexpected;
      tx_restart_q <= tx_fs_unexpected;
    end
  end

  // ----------------------------------------------------------------
  // Requests to CPU and DMA
  // ----------------------------------------------------------------
  // DMA follows the ready flags and ignores the CPU gates
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_dma_q <= 1'b0;
      tx_dma_q <= 1'b0;
    end else begin
      rx_dma_q <= rx_word_ready_q;
      tx_dma_q <= tx_word_ready_q;
    end
  end

  // Receive CPU line
  spis_irq_sel u_rx_sel (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .mode        (rx_irq_mode),
    .gate        (rx_irq_gate),
    .src_word    (rx_word_ready_q),
    .src_block   (rx_block_end),
    .src_fsync   (rx_frame_sync),
    .src_syncerr (rx_sync_error_q),
    .irq_q       (rx_cpu_irq_line)
  );

  // Transmit CPU line
  spis_irq_sel u_tx_sel (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .mode        (tx_irq_mode),
    .gate        (tx_irq_gate),
    .src_word    (tx_word_ready_q),
    .src_block   (tx_block_end),
    .src_fsync   (tx_frame_sync),
    .src_syncerr (tx_sync_error_q),
    .irq_q       (tx_cpu_irq_line)
  );

  // ----------------------------------------------------------------
  // Transmit channel selection
  // ----------------------------------------------------------------
  // Symmetric mode borrows enable from the receive side
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      slot_en_q <= 1'b1;
      slot_um_q <= 1'b1;
    end else begin
      case (tx_multichannel_mode)
        SPIS_MC_OFF: begin
          slot_en_q <= 1'b1;
          slot_um_q <= 1'b1;
        end
        SPIS_MC_SELECT: begin
          slot_en_q <= chan_bit;
          slot_um_q <= chan_bit;
        end
        SPIS_MC_MASKED: begin
          slot_en_q <= 1'b1;
          slot_um_q <= chan_bit;
        end
        SPIS_MC_SYMMETRIC: begin
          slot_en_q <= rx_chan_enabled;
          slot_um_q <= chan_bit;
        end
        default: begin
          slot_en_q <= 1'b1;
          slot_um_q <= 1'b1;
        end
      endcase
    end
  end

  // Outputs straight from flops
  assign hreadyout      = hreadyout_q;
  assign hresp          = hresp_q;
  assign hrdata         = hrdata_q;
  assign rx_restart     = rx_restart_q;
  assign tx_restart     = tx_restart_q;
  assign rx_dma_event   = rx_dma_q;
  assign tx_dma_event   = tx_dma_q;
  assign tx_slot_enable = slot_en_q;
  assign tx_slot_unmask = slot_um_q;
  assign tx_data_out    = {tx_high_q, tx_low_q};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_addr_taken;
    bus_q == SPIS_BUS_IDLE && hsel && htrans[1] && hready;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_bus_one_wait: assert property (s_addr_taken |=> s_one_wait)
    else $error("bus answer not after exactly one wait");
  a_rx_word_line: assert property (rx_irq_mode == SPIS_SRC_WORD && rx_irq_gate && rx_word_ready_q
                                   |=> rx_cpu_irq_line)
    else $error("receive word ready did not raise its line");
  a_tx_err_line: assert property (tx_irq_mode == SPIS_SRC_SYNCERR && tx_irq_gate && tx_sync_error_q
                                  |=> tx_cpu_irq_line)
    else $error("transmit sync error did not raise its line");
  a_overrun_set: assert property (rx_word_done && rx_word_ready_q && !rd_rx_low |=> rx_overrun_q)
    else $error("overrun not flagged");
  a_rx_sync_abort: assert property (rx_fs_unexpected |=> rx_sync_error_q && rx_restart)
    else $error("receive sync error not flagged with restart");
  a_tx_sync_abort: assert property (tx_fs_unexpected |=> tx_sync_error_q && tx_restart)
    else $error("transmit sync error not flagged with restart");
  a_rx_gate_off: assert property (!rx_irq_gate |=> !rx_cpu_irq_line)
    else $error("receive line high while gated off");
  a_tx_gate_off: assert property (!tx_irq_gate |=> !tx_cpu_irq_line)
    else $error("transmit line high while gated off");
  a_rsvd_zero: assert property ((irq_en_q & ~`SPIS_IEN_MASK) == 16'h0000)
    else $error("reserved enable bits set");
  a_dma_follow: assert property (!$past(sys_rst) |-> rx_dma_event == $past(rx_word_ready_q)
                                 && tx_dma_event == $past(tx_word_ready_q))
    else $error("DMA request does not follow ready flag");
  a_chan_select: assert property (tx_multichannel_mode == SPIS_MC_SELECT && tx_wide_channel_select
                                  |=> tx_slot_enable == $past(chan_en_q[tx_chan_idx[6:4]][tx_chan_idx[3:0]])
                                      && tx_slot_unmask == tx_slot_enable)
    else $error("selected channel map wrong");

endmodule

/* File: testbench/spis_cpu_dma_model.sv */
// Behavioural CPU interrupt controller and DMA controller facing the block
`timescale 1ns/100ps

module spis_cpu_dma_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Requests from the block
  input  wire logic       rx_cpu_irq_line,
  input  wire logic       tx_cpu_irq_line,
  input  wire logic       rx_dma_event,
  // Requests taken so far
  output logic [7:0]      rx_cnt_q,
  output logic [7:0]      tx_cnt_q,
  output logic [7:0]      dma_cnt_q
);
  logic rx_q, tx_q, dma_q;

  // Rising edges only: a level held for many cycles is one request, as a CPU sees it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      {rx_q, tx_q, dma_q} <= 3'h0;
      {rx_cnt_q, tx_cnt_q, dma_cnt_q} <= 24'h0;
    end else begin
      {rx_q, tx_q, dma_q} <= {rx_cpu_irq_line, tx_cpu_irq_line, rx_dma_event};
      if (rx_cpu_irq_line && !rx_q) rx_cnt_q <= rx_cnt_q + 8'h01;
      if (tx_cpu_irq_line && !tx_q) tx_cnt_q <= tx_cnt_q + 8'h01;
      if (rx_dma_event && !dma_q) dma_cnt_q <= dma_cnt_q + 8'h01;
    end
  end
endmodule

/* File: testbench/test_serial_port_interrupt_select.sv */
// Self-checking bench of the serial port interrupt select block
`timescale 1ns/100ps

module test_serial_port_interrupt_select;
  import spis_pkg::*;
  logic ref_clk = 0, sys_rst = 1, hwrite = 0, hreadyout, hresp;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rx_word = 0, tx_data_out, r;
  logic rx_word_done = 0, tx_word_taken = 0, tx_slot_enable, tx_slot_unmask;
  logic [2:0] rev = 0, tev = 0; // Block end, frame sync, unexpected sync
  logic [6:0] tx_chan_idx = 0;
  logic rx_restart, tx_restart, rx_cpu_irq_line, tx_cpu_irq_line, rx_dma_event, tx_dma_event;
  logic [7:0] rx_cnt, tx_cnt, dma_cnt;
  int n_mismatch = 0, comparisons = 0;

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  spis_top spis_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_word_done(rx_word_done), .rx_word(rx_word), .rx_block_end(rev[0]),
    .rx_frame_sync(rev[1]), .rx_fs_unexpected(rev[2]), .tx_word_taken(tx_word_taken),
    .tx_block_end(tev[0]), .tx_frame_sync(tev[1]), .tx_fs_unexpected(tev[2]), .tx_chan_idx(tx_chan_idx),
    .rx_chan_enabled(1'b0), .tx_slot_enable(tx_slot_enable), .tx_slot_unmask(tx_slot_unmask),
    .tx_data_out(tx_data_out), .rx_restart(rx_restart), .tx_restart(tx_restart),
    .rx_cpu_irq_line(rx_cpu_irq_line), .tx_cpu_irq_line(tx_cpu_irq_line),
    .rx_dma_event(rx_dma_event), .tx_dma_event(tx_dma_event));

  spis_cpu_dma_model spis_cpu_dma_model_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .rx_cpu_irq_line(rx_cpu_irq_line), .tx_cpu_irq_line(tx_cpu_irq_line), .rx_dma_event(rx_dma_event),
    .rx_cnt_q(rx_cnt), .tx_cnt_q(tx_cnt), .dma_cnt_q(dma_cnt));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  // Waits for hready high at an edge; values seen are those sampled at that edge
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask

  // One-cycle event pulse; an unexpected sync must bring the restart pulse one edge later
  task automatic ev(input int d, input int i);
    if (d == 1) tev[i] <= 1'b1;
    else rev[i] <= 1'b1;
    @(posedge ref_clk);
    {rev, tev} <= 6'h0;
    @(posedge ref_clk);
    if (i == 2) chk("restart", 1, d ? tx_restart : rx_restart);
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic word(input logic [31:0] w);
    rx_word_done <= 1'b1;
    rx_word <= w;
    @(posedge ref_clk);
    rx_word_done <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    bus(0, 8'h14, 0); chk("status reset", 32'h8, r);
    chk("response okay", 0, hresp);
    bus(0, 8'h18, 0); chk("enable reset", 32'h0, r);
    bus(1, 8'h18, 32'hffff); bus(0, 8'h18, 0); chk("enable reserved", 32'h5, r);
    bus(1, 8'h40, 32'h1); bus(0, 8'h40, 0); chk("unmapped", 32'h0, r);
  endtask

  // Modes 1 to 3 in each direction: of three events exactly the selected one interrupts
  task automatic t_modes;
    logic [7:0] c;
    for (int d = 0; d < 2; d++) begin
      for (int m = 1; m < 4; m++) begin
        bus(1, 8'h10, d ? (m << 2) | 1 : m | 4);
        bus(1, 8'h18, d ? 32'h1 : 32'h4);
        c = d ? tx_cnt : rx_cnt;
        for (int i = 0; i < 3; i++) ev(d, i);
        chk("irq count", c + 8'h1, d ? tx_cnt : rx_cnt);
        bus(0, 8'h14, 0); chk("sync error flag", 1, r[d ? 4 : 2]);
        bus(1, 8'h14, 32'h16);
        repeat (3) @(posedge ref_clk);
        chk("line after clear", 0, d ? tx_cpu_irq_line : rx_cpu_irq_line);
      end
    end
  endtask

  task automatic t_rx_word;
    bus(1, 8'h10, 32'h4); bus(1, 8'h18, 32'h4);
    word(32'h1234abcd);
    chk("rx line", 1, rx_cpu_irq_line);
    chk("rx dma", 1, rx_dma_event);
    word(32'h0);
    bus(0, 8'h14, 0); chk("overrun", 32'hb, r);
    bus(0, 8'h00, 0); chk("rx high", 32'h1234, r);
    bus(0, 8'h04, 0); chk("rx low", 32'habcd, r);
    repeat (3) @(posedge ref_clk);
    chk("rx line freed", 0, rx_cpu_irq_line);
    bus(1, 8'h18, 32'h0); word(32'h5);
    chk("rx gated", 0, rx_cpu_irq_line);
    chk("dma ungated", 1, rx_dma_event);
    chk("dma count", 2, dma_cnt);
    bus(0, 8'h04, 0);
  endtask

  task automatic t_tx_word;
    bus(1, 8'h10, 32'h1); bus(1, 8'h18, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk("tx line", 1, tx_cpu_irq_line);
    bus(1, 8'h08, 32'h5a5a); bus(1, 8'h0c, 32'hc3c3);
    repeat (3) @(posedge ref_clk);
    chk("tx pair", 32'h5a5ac3c3, tx_data_out);
    chk("tx line busy", 0, tx_cpu_irq_line);
    chk("tx dma busy", 0, tx_dma_event);
    tx_word_taken <= 1'b1;
    @(posedge ref_clk);
    tx_word_taken <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("tx line again", 1, tx_cpu_irq_line);
    chk("tx dma again", 1, tx_dma_event);
    bus(1, 8'h18, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk("tx gated", 0, tx_cpu_irq_line);
  endtask

  // Wide selection, mode 01: bit b of block b enables channel 17b, its neighbour stays off
  task automatic t_chan;
    bus(1, 8'h10, 32'h55);
    for (int b = 0; b < 8; b++) begin
      bus(1, 8'h20 + 8'(4 * b), 32'h1 << b);
      bus(0, 8'h20 + 8'(4 * b), 0); chk("chan reg", 32'h1 << b, r);
      for (int k = b; k < b + 2; k++) begin
        tx_chan_idx <= 7'(16 * b + k);
        repeat (3) @(posedge ref_clk);
        chk("slot enable", k == b, tx_slot_enable);
        chk("slot unmask", k == b, tx_slot_unmask);
      end
    end
    // Mode 10: every channel enabled, channel 113 (block 7 bit 1) stays masked
    bus(1, 8'h10, 32'h65);
    tx_chan_idx <= 7'd113;
    repeat (3) @(posedge ref_clk);
    chk("masked enable", 1, tx_slot_enable);
    chk("masked unmask", 0, tx_slot_unmask);
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_modes();
    t_rx_word();
    t_tx_word();
    t_chan();
    final_report();
  end
endmodule
